// File: slsl_core.sv
`timescale 1ns/100ps
module slsl_core (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire slsl_pkg::slsl_pins_s pins,
  output logic                      serial_out,
  output logic [15:0]               sink_output_n
);

  logic                 clk_prev_q;
  logic [15:0]          shift_q;
  logic [15:0]          shift_d;
  logic [15:0]          latch_q;
  logic [15:0]          latch_d;
  logic                 sout_q;
  slsl_pkg::slsl_edge_e edge_cls;

  // Shift clock is sampled by ref_clk; the host keeps it well below 62.5 MHz
  // so each level lasts at least one sample.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= pins.shift_clk;
    end
  end

  // Rise detection is shared by the edge class and the shift checks,
  // so one definition keeps them from drifting apart
  function automatic logic is_rise(input logic now_lvl, input logic prev_lvl);
    return now_lvl && !prev_lvl;
  endfunction

  // Only a low-to-high transition counts; a falling edge is simply ignored
  always_comb begin
    if (is_rise(pins.shift_clk, clk_prev_q)) begin
      edge_cls = slsl_pkg::SLSL_EDGE_RISE;
    end else begin
      edge_cls = slsl_pkg::SLSL_EDGE_NONE;
    end
  end

  // Next register contents: new bit enters stage 0
  always_comb begin
    case (edge_cls)
      slsl_pkg::SLSL_EDGE_RISE: shift_d = {shift_q[14:0], pins.serial_in};
      default:                  shift_d = shift_q;
    endcase
  end

  // Shift register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_q <= slsl_pkg::SHIFT_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // Cascade output taken after the shift so it moves on rising edges only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sout_q <= 1'b0;
    end else begin
      sout_q <= shift_d[slsl_pkg::LAST_STAGE];
    end
  end

  assign serial_out = sout_q;

  // Transparent latch modelled as a flop that loads each cycle while open.
  // It follows the post-shift value, so a rising edge with the strobe high
  // reaches the latches in the same cycle, as a transparent latch would.
  always_comb begin
    latch_d = pins.latch_strobe ? shift_d : latch_q;
  end

  // Latch bank
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_q <= slsl_pkg::LATCH_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Output gating; contents after reset are zero, so outputs kept enabled
  // through a reset stay dark until a word is latched.
  slsl_sink_stage u_sink (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .latch_word    (latch_q),
    .out_en_n      (pins.out_en_n),
    .sink_output_n (sink_output_n)
  );

  // Sequences for the shift path
  sequence s_rise;
    is_rise(pins.shift_clk, clk_prev_q);
  endsequence

  sequence s_no_rise;
    !is_rise(pins.shift_clk, clk_prev_q);
  endsequence

  // Shift with the latches open: the new word passes straight through
  sequence s_open_rise;
    pins.latch_strobe && is_rise(pins.shift_clk, clk_prev_q);
  endsequence

  // Shift with the latches shut: the outputs must not see it
  sequence s_shut_rise;
    !pins.latch_strobe && is_rise(pins.shift_clk, clk_prev_q);
  endsequence

  // Latches open with the register idle: a plain copy
  sequence s_open_still;
    pins.latch_strobe && !is_rise(pins.shift_clk, clk_prev_q);
  endsequence

  // A full latch pulse: strobe open for a cycle or more, then closed
  sequence s_strobe_close;
    pins.latch_strobe ##1 !pins.latch_strobe;
  endsequence

  a_shift_on_rise : assert property (@(posedge ref_clk) disable iff (rst)
    s_rise |=> (shift_q == {$past(shift_q[14:0]), $past(pins.serial_in)}))
    else $error("Register did not shift on rising edge");

  a_hold_no_rise : assert property (@(posedge ref_clk) disable iff (rst)
    s_no_rise |=> $stable(shift_q) && $stable(serial_out))
    else $error("Register changed without rising edge");

  a_sout_last_stage : assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (serial_out == shift_q[15]))
    else $error("Serial output is not last stage");

  a_latch_follow : assert property (@(posedge ref_clk) disable iff (rst)
    pins.latch_strobe |=> (latch_q == shift_q))
    else $error("Latches not following register");

  a_latch_hold : assert property (@(posedge ref_clk) disable iff (rst)
    !pins.latch_strobe |=> $stable(latch_q))
    else $error("Latches changed while strobe low");

  a_bit_through_chain : assert property (@(posedge ref_clk) disable iff (rst)
    (s_rise ##1 s_no_rise) |=> ##0 (serial_out == $past(shift_q[15], 1)))
    else $error("Serial output moved without rising edge");

  // Open latches take the freshly shifted word in the same cycle
  property p_open_shift;
    @(posedge ref_clk) disable iff (rst)
    s_open_rise |=> (latch_q == {$past(shift_q[14:0]), $past(pins.serial_in)});
  endproperty

  a_open_shift_latch : assert property (p_open_shift)
    else $error("Open latches missed the shifted word");

  // Shut latches ignore shifting, which lets a new word load unseen
  property p_shut_shift;
    @(posedge ref_clk) disable iff (rst)
    s_shut_rise |=> $stable(latch_q);
  endproperty

  a_shut_shift_hold : assert property (p_shut_shift)
    else $error("Shut latches moved during a shift");

  // Open latches with an idle register copy it unchanged
  property p_open_still;
    @(posedge ref_clk) disable iff (rst)
    s_open_still |=> (latch_q == $past(shift_q));
  endproperty

  a_open_still_copy : assert property (p_open_still)
    else $error("Open latches do not match the register");

  // Latch contents only ever move while the strobe is high
  property p_latch_open_only;
    @(posedge ref_clk) disable iff (rst)
    $changed(latch_q) |-> $past(pins.latch_strobe);
  endproperty

  a_latch_open_only : assert property (p_latch_open_only)
    else $error("Latches changed with the strobe low");

  // The cascade pin only moves after a sampled rise; a downstream
  // device clocked by the same edge must still see the previous bit
  property p_sout_rise_only;
    @(posedge ref_clk) disable iff (rst)
    $changed(serial_out) |-> ($past(pins.shift_clk) && !$past(clk_prev_q));
  endproperty

  a_sout_rise_only : assert property (p_sout_rise_only)
    else $error("Serial output moved without a rise");

  // Each rise passes the second-to-last stage on to the cascade pin
  property p_sout_next_stage;
    @(posedge ref_clk) disable iff (rst)
    s_rise |=> (serial_out == $past(shift_q[14]));
  endproperty

  a_sout_next_stage : assert property (p_sout_next_stage)
    else $error("Serial output skipped a stage");

  // A finished strobe pulse with outputs enabled shows the latched word
  property p_pulse_to_sinks;
    @(posedge ref_clk) disable iff (rst)
    (s_strobe_close ##0 !pins.out_en_n) |=> (sink_output_n == ~latch_q);
  endproperty

  a_pulse_to_sinks : assert property (p_pulse_to_sinks)
    else $error("Sinks do not show the word just latched");

endmodule

// File: slsl_pkg.sv
package slsl_pkg;

  // Channel count and shift depth
  localparam int unsigned CHANNELS = 16;
  localparam int unsigned LAST_STAGE = CHANNELS - 1;

  // Values after reset: all register stages and latches clear, outputs off
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'h0000;

  // Sink pins with every channel dark (active low, so all ones)
  localparam logic [15:0] SINK_OFF = 16'hFFFF;

  // Host-side pin group, sampled synchronously to ref_clk
  typedef struct packed {
    logic shift_clk;     // Serial shift clock from host
    logic serial_in;     // Serial data in
    logic latch_strobe;  // High: latches follow the register
    logic out_en_n;      // Low: sink outputs enabled
  } slsl_pins_s;

  // Edge classes of the sampled shift clock
  typedef enum logic [1:0] {
    SLSL_EDGE_NONE = 2'h1,
    SLSL_EDGE_RISE = 2'h2
  } slsl_edge_e;

endpackage

// File: slsl_sink_stage.sv
`timescale 1ns/100ps
// Output stage: gates the latch bank onto the active-low sink pins
module slsl_sink_stage (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] latch_word,
  input  wire logic        out_en_n,
  output logic      [15:0] sink_output_n
);

  logic [15:0] sink_q;
  logic [15:0] sink_d;

  // One bit lit drives its pin low; disabled means all pins high (off)
  always_comb begin
    sink_d = out_en_n ? slsl_pkg::SINK_OFF : ~latch_word;
  end

  // Registered so the pins never glitch on decode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sink_q <= slsl_pkg::SINK_OFF;
    end else begin
      sink_q <= sink_d;
    end
  end

  assign sink_output_n = sink_q;

  a_sink_off_disabled : assert property (@(posedge ref_clk) disable iff (rst)
    out_en_n |=> (sink_output_n == slsl_pkg::SINK_OFF))
    else $error("Sink pins not off while disabled");

  a_sink_follows_latch : assert property (@(posedge ref_clk) disable iff (rst)
    !out_en_n |=> (sink_output_n == ~$past(latch_word)))
    else $error("Sink pin does not reflect latched bit");

endmodule

// File: slsl_host.sv
`timescale 1ns/100ps
// Host model: bit-bangs a word, then pulses the strobe
module slsl_host (
  input  wire logic            ref_clk,
  output slsl_pkg::slsl_pins_s pins
);
  // Clock low, outputs dark until a full word is latched
  initial begin
    pins.shift_clk    = 1'b0;
    pins.serial_in    = 1'b0;
    pins.latch_strobe = 1'b0;
    pins.out_en_n     = 1'b1;
  end
  // All pin changes land just after a system clock edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Three cycles per level: a 48 ns period keeps under the shift clock limit
  task automatic shift_bit(input logic b);
    pins.serial_in = b;
    step(3);
    pins.shift_clk = 1'b1;
    step(3);
    pins.shift_clk = 1'b0;
  endtask
  // Most significant bit first, so it ends in the last stage
  task automatic shift_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      shift_bit(w[i]);
    end
    pins.serial_in = ~w[0]; // Stale data line, not the last bit
  endtask
  // Strobe pulse low to high and back, after the word is in
  task automatic latch();
    pins.latch_strobe = 1'b1;
    step(2);
    pins.latch_strobe = 1'b0;
    step(1);
  endtask
  // Hold the latches open or shut for transparent shifting
  task automatic open_latch(input logic lvl);
    pins.latch_strobe = lvl;
    step(1);
  endtask
  // Output enable changes only once a word has been latched
  task automatic enable(input logic en_n);
    pins.out_en_n = en_n;
    step(3);
  endtask
endmodule

// File: slsl_core_test.sv
`timescale 1ns/100ps
// Bench: host model drives the pins, scenarios judge the outputs
module slsl_core_test;
  logic                 ref_clk;
  logic                 rst;
  logic                 serial_out;
  logic [15:0]          sink_output_n;
  slsl_pkg::slsl_pins_s pins;
  int                   fails;
  int                   comparisons;
  slsl_host host (
    .ref_clk (ref_clk),
    .pins    (pins)
  );
  slsl_core DUT (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .pins          (pins),
    .serial_out    (serial_out),
    .sink_output_n (sink_output_n)
  );
  // Free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Compare for the sink pins
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: sinks %h expected %h", $time, got, exp);
    end
  endtask
  // Compare for the cascade pin
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: serial_out %b expected %b", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Latched word stays dark until enabled, then lit bits pull low
  task automatic sc_load();
    host.shift_word(16'hA53C);
    host.latch();
    chk(sink_output_n, 16'hFFFF);
    host.enable(1'b0);
    chk(sink_output_n, 16'h5AC3);
  endtask
  // Shifting with strobe low leaves the outputs alone
  task automatic sc_hold();
    host.shift_word(16'h8001);
    chk(sink_output_n, 16'h5AC3);
    chk_bit(serial_out, 1'b1);
    host.latch();
    chk(sink_output_n, 16'h7FFE);
  endtask
  // Disable blanks every channel, enable restores them
  task automatic sc_blank();
    host.enable(1'b1);
    chk(sink_output_n, 16'hFFFF);
    host.enable(1'b0);
    chk(sink_output_n, 16'h7FFE);
  endtask
  // Open latches: each rise moves the cascade pin and the lit pins together
  task automatic sc_cascade();
    logic [31:0] chain;
    chain = {16'h8001, 16'h3C96};
    host.open_latch(1'b1);
    for (int k = 1; k <= 16; k++) begin
      host.shift_bit(chain[16 - k]);
      chk_bit(serial_out, chain[31 - k]);
      chk(sink_output_n, ~chain[31 - k -: 16]);
    end
    host.open_latch(1'b0);
    host.shift_word(16'hFFFF);
    chk(sink_output_n, 16'hC369);
  endtask
  // Reset in mid-run clears register and latches; enabled zeros stay dark
  task automatic sc_reset();
    host.latch();
    chk(sink_output_n, 16'h0000);
    rst = 1'b1;
    host.step(2);
    chk(sink_output_n, 16'hFFFF);
    rst = 1'b0;
    chk_bit(serial_out, 1'b0);
    host.step(2);
    chk(sink_output_n, 16'hFFFF);
    host.shift_word(16'h00FF);
    host.latch();
    chk(sink_output_n, 16'hFF00);
  endtask
  // Watchdog: a hang counts against the run
  initial begin
    #200000;
    fails++;
    test_done();
  end
  // Main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    host.step(4);
    rst = 1'b0;
    chk(sink_output_n, 16'hFFFF);
    chk_bit(serial_out, 1'b0);
    sc_load();
    sc_hold();
    sc_blank();
    sc_cascade();
    sc_reset();
    test_done();
  end
endmodule
